// ==== rtl/hpm_mailbox.sv ====
/*
  host port mailbox, message flags and host-only status port.
  assumes cpu and host access strobes are one-cycle pulses on clock_i;
  usb engine events are one-cycle pulses from logic on the same clock.
*/
`timescale 1ns/1ps
module hpm_mailbox (
  input wire logic clock_i, // 250 MHz system clock
  input wire logic rst_b_i, // async reset, active low
  input wire hpm_pkg::hpm_acc_t cpu_i, // cpu access
  output logic [15:0] cpu_rdata_o, // cpu read data
  input wire hpm_pkg::hpm_acc_t host_i, // host memory access
  output logic [15:0] host_rdata_o, // host memory read data
  input wire logic host_stat_rd_i, // host status port read strobe
  output logic [15:0] host_status_o, // status port word
  input wire logic [15:0] irq_route_i, // routing control word
  input wire logic [1:0] msg_irq_en_i, // message irq enables b,a
  input wire logic rx_full_en_i, // receive-full irq enable
  input wire logic tx_empty_en_i, // transmit-empty irq enable
  input wire logic [15:0] usb_event_i, // engine event pulses, status positions
  input wire logic [15:0] usb_evclr_i, // engine event clears, status positions
  input wire logic vbus_valid_i, // bus voltage above threshold (pin)
  input wire logic otg_id_i, // identification pin
  output logic mbox_receive_full_irq_o, // cpu receive-full irq
  output logic mbox_transmit_empty_irq_o, // cpu transmit-empty irq
  output logic [15:0] cpu_events_o, // events left with the cpu
  output logic host_port_irq_out_o // host interrupt output
);
  import hpm_pkg::*;

  hpm_state_t s_reg;
  hpm_state_t s_next;
  logic c_mb_rd, c_mb_wr, h_mb_rd, h_mb_wr, c_ma_wr, c_mb2_wr, h_ma_rd, h_mb2_rd;
  logic [15:0] stat;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input hpm_acc_t a, input logic [15:0] ad);
    hit = (a.addr == ad);
  endfunction

  // status port is not on the cpu map, so no cpu decode reaches it
  assign c_mb_rd = cpu_i.rd && hit(cpu_i, HPM_MBOX_ADDR);
  assign c_mb_wr = cpu_i.wr && hit(cpu_i, HPM_MBOX_ADDR);
  assign c_ma_wr = cpu_i.wr && hit(cpu_i, HPM_MSG_A_ADDR);
  assign c_mb2_wr = cpu_i.wr && hit(cpu_i, HPM_MSG_B_ADDR);
  assign h_mb_rd = host_i.rd && hit(host_i, HPM_MBOX_ADDR);
  assign h_mb_wr = host_i.wr && hit(host_i, HPM_MBOX_ADDR);
  assign h_ma_rd = host_i.rd && hit(host_i, HPM_MSG_A_ADDR);
  assign h_mb2_rd = host_i.rd && hit(host_i, HPM_MSG_B_ADDR);

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  // reserved bits 13 and 11 read zero
  always_comb begin
    stat = 16'h0000;
    stat[HPM_B_VBUS] = s_reg.vbus_sync[1];
    stat[HPM_B_ID] = s_reg.id_sync[1];
    // only routed engine events show to the host
    stat = stat | (s_reg.events & irq_route_i & HPM_ROUTED_MASK);
    stat[HPM_B_MBIN] = s_reg.mb_in;
    stat[HPM_B_MBOUT] = s_reg.mb_out;
    stat[HPM_B_MSGA] = s_reg.msg_a;
    stat[HPM_B_MSGB] = s_reg.msg_b;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.vbus_sync = {s_reg.vbus_sync[0], vbus_valid_i};
    s_next.id_sync = {s_reg.id_sync[0], otg_id_i};
    // host writes win on a same-cycle collision; cpu write still flags
    if (c_mb_wr) s_next.mbox = cpu_i.wdata;
    if (h_mb_wr) s_next.mbox = host_i.wdata;
    // clears first, sets after, so a coinciding event is kept
    if (c_mb_rd) s_next.rx_full = 1'b0;
    if (h_mb_wr && rx_full_en_i) s_next.rx_full = 1'b1;
    if (c_mb_wr) s_next.tx_empty = 1'b0;
    if (h_mb_rd && tx_empty_en_i) s_next.tx_empty = 1'b1;
    if (c_mb_rd) s_next.mb_in = 1'b0;
    if (h_mb_wr) s_next.mb_in = 1'b1;
    if (h_mb_rd) s_next.mb_out = 1'b0;
    if (c_mb_wr) s_next.mb_out = 1'b1;
    if (h_ma_rd) s_next.msg_a = 1'b0;
    if (c_ma_wr) s_next.msg_a = 1'b1; // data ignored
    if (h_mb2_rd) s_next.msg_b = 1'b0;
    if (c_mb2_wr) s_next.msg_b = 1'b1;
    s_next.events = (s_reg.events & ~usb_evclr_i) | (usb_event_i & HPM_ROUTED_MASK);
    // registered or of mb_out, the enabled message flags and the routed events
    s_next.irq = s_reg.mb_out | (s_reg.msg_a & msg_irq_en_i[0]) |
                 (s_reg.msg_b & msg_irq_en_i[1]) |
                 (|(s_reg.events & irq_route_i & HPM_ROUTED_MASK));
    s_next.cpu_rdata = c_mb_rd ? s_reg.mbox : 16'h0000;
    // status read is served here directly, no cpu cycle
    s_next.host_rdata = h_mb_rd ? s_reg.mbox : (host_stat_rd_i ? stat : 16'h0000);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
      s_reg.mbox <= HPM_MBOX_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cpu_rdata_o = s_reg.cpu_rdata;
  assign host_rdata_o = s_reg.host_rdata;
  assign host_status_o = stat;
  assign mbox_receive_full_irq_o = s_reg.rx_full;
  assign mbox_transmit_empty_irq_o = s_reg.tx_empty;
  // unrouted events stay with the cpu
  assign cpu_events_o = s_reg.events & ~irq_route_i & HPM_ROUTED_MASK;
  assign host_port_irq_out_o = s_reg.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence cpu_wr_seq;
    c_mb_wr && !h_mb_rd;
  endsequence

  // host mailbox read with no cpu write racing it
  sequence host_rd_seq;
    h_mb_rd && !c_mb_wr;
  endsequence

  // no message or routed event left to hold the host line up
  sequence irq_quiet_seq;
    !(host_status_o[HPM_B_MSGA] && msg_irq_en_i[0]) &&
    !(host_status_o[HPM_B_MSGB] && msg_irq_en_i[1]) &&
    ((host_status_o & irq_route_i & HPM_ROUTED_MASK) == 16'h0000);
  endsequence

  a_msg_flag_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_ma_wr |=> host_status_o[HPM_B_MSGA]) else $error("msg a flag not set");
  a_mbox_host_wr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_wr |=> s_reg.mbox == $past(host_i.wdata)) else $error("mailbox not stored");
  a_rx_full_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_wr && rx_full_en_i |=> mbox_receive_full_irq_o) else $error("rx full not set");
  a_rx_full_clr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_mb_rd && !h_mb_wr |=> !mbox_receive_full_irq_o) else $error("rx full not cleared");
  a_tx_empty_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_rd && tx_empty_en_i |=> mbox_transmit_empty_irq_o) else $error("tx empty not set");
  a_tx_empty_clr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_mb_wr && !h_mb_rd |=> !mbox_transmit_empty_irq_o) else $error("tx empty stuck");
  a_host_irq_raise: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cpu_wr_seq |-> ##2 host_port_irq_out_o) else $error("host irq not raised");
  a_mbout_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_rd && !c_mb_wr |=> !host_status_o[HPM_B_MBOUT]) else $error("mbout not cleared");
  a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !host_status_o[13] && !host_status_o[11]) else $error("reserved bit set");
  a_id_follow: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ##2 host_status_o[HPM_B_ID] == $past(otg_id_i, 2)) else $error("otg_ident_flag lags");

  // ---------------------------------------------------------------
  // mailbox word and read data
  // ---------------------------------------------------------------
  // cpu data lands when the host is not writing the same cycle
  a_mbox_cpu_wr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_mb_wr && !h_mb_wr |=>
    s_reg.mbox == $past(cpu_i.wdata))
    else $error("cpu mailbox write lost");
  // the word only moves on a mailbox write
  a_mbox_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !c_mb_wr && !h_mb_wr |=>
    $stable(s_reg.mbox))
    else $error("mailbox changed unasked");
  // cpu read returns the stored word one cycle on
  a_cpu_rdata: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_mb_rd |=>
    cpu_rdata_o == $past(s_reg.mbox))
    else $error("cpu read data wrong");
  // host read returns the stored word one cycle on
  a_host_rdata: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_rd |=>
    host_rdata_o == $past(s_reg.mbox))
    else $error("host read data wrong");
  // status poll is answered from the flags alone
  a_stat_rdata: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    host_stat_rd_i && !h_mb_rd |=>
    host_rdata_o == $past(host_status_o))
    else $error("status read data wrong");
  // cpu sees nothing but the mailbox, never the status word
  a_cpu_rd_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !c_mb_rd |=>
    cpu_rdata_o == 16'h0000)
    else $error("cpu read data without mailbox read");

  // ---------------------------------------------------------------
  // cpu-side mailbox interrupts
  // ---------------------------------------------------------------
  // receive-full moves only on host write or cpu read
  a_rx_full_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !h_mb_wr && !c_mb_rd |=>
    $stable(mbox_receive_full_irq_o))
    else $error("rx full moved unasked");
  // a disabled receive-full stays low
  a_rx_full_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_wr && !rx_full_en_i && !mbox_receive_full_irq_o |=>
    !mbox_receive_full_irq_o)
    else $error("rx full set while disabled");
  // transmit-empty moves only on host read or cpu write
  a_tx_empty_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !h_mb_rd && !c_mb_wr |=>
    $stable(mbox_transmit_empty_irq_o))
    else $error("tx empty moved unasked");
  // a disabled transmit-empty stays low
  a_tx_empty_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_rd && !tx_empty_en_i && !mbox_transmit_empty_irq_o |=>
    !mbox_transmit_empty_irq_o)
    else $error("tx empty set while disabled");

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // host write marks an incoming message
  a_mbin_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb_wr |=>
    host_status_o[HPM_B_MBIN])
    else $error("mbin not set");
  // cpu read clears the incoming mark
  a_mbin_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_mb_rd && !h_mb_wr |=>
    !host_status_o[HPM_B_MBIN])
    else $error("mbin not cleared");
  // cpu write marks an outgoing message
  a_mbout_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_mb_wr |=>
    host_status_o[HPM_B_MBOUT])
    else $error("mbout not set");
  // second message register flags on any write
  a_msg_b_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    c_mb2_wr |=>
    host_status_o[HPM_B_MSGB])
    else $error("msg b flag not set");
  // host read of the first message register clears its flag
  a_msg_a_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_ma_rd && !c_ma_wr |=>
    !host_status_o[HPM_B_MSGA])
    else $error("msg a flag not cleared");
  // host read of the second message register clears its flag
  a_msg_b_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    h_mb2_rd && !c_mb2_wr |=>
    !host_status_o[HPM_B_MSGB])
    else $error("msg b flag not cleared");
  // bus voltage flag trails its pin by the two sync flops
  a_vbus_follow: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ##2 host_status_o[HPM_B_VBUS] == $past(vbus_valid_i, 2))
    else $error("bus_voltage_valid_flag lags");

  // ---------------------------------------------------------------
  // engine events and routing
  // ---------------------------------------------------------------
  // a pulse is latched, either on the host side or the cpu side
  a_event_latch: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    |(usb_event_i & HPM_ROUTED_MASK) |=>
    ((host_status_o | cpu_events_o) & $past(usb_event_i) & HPM_ROUTED_MASK) ==
    ($past(usb_event_i) & HPM_ROUTED_MASK))
    else $error("event not latched");
  // a clear without a coinciding pulse empties the event
  a_event_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    |(usb_evclr_i & ~usb_event_i & HPM_ROUTED_MASK) |=>
    ((host_status_o | cpu_events_o) & $past(usb_evclr_i & ~usb_event_i) &
    HPM_ROUTED_MASK) == 16'h0000)
    else $error("event not cleared");
  // unrouted events never show on the host side
  a_unrouted_hidden: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (host_status_o & HPM_ROUTED_MASK & ~irq_route_i) == 16'h0000)
    else $error("unrouted event visible to host");
  // routed events never stay with the cpu
  a_cpu_ev_split: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (cpu_events_o & irq_route_i) == 16'h0000)
    else $error("routed event left with cpu");

  // ---------------------------------------------------------------
  // host interrupt line
  // ---------------------------------------------------------------
  // an enabled first message flag raises the line
  a_msg_a_irq: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    host_status_o[HPM_B_MSGA] && msg_irq_en_i[0] |=>
    host_port_irq_out_o)
    else $error("msg a irq missing");
  // an enabled second message flag raises the line
  a_msg_b_irq: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    host_status_o[HPM_B_MSGB] && msg_irq_en_i[1] |=>
    host_port_irq_out_o)
    else $error("msg b irq missing");
  // a routed event raises the line
  a_route_irq: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    |(host_status_o & irq_route_i & HPM_ROUTED_MASK) |=>
    host_port_irq_out_o)
    else $error("routed event irq missing");
  // host mailbox read drops the line when nothing else holds it
  a_host_irq_drop: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    host_rd_seq ##1 irq_quiet_seq |=>
    !host_port_irq_out_o)
    else $error("host irq not dropped");
  // the line is never up without a cause one cycle before
  a_irq_cause: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    host_port_irq_out_o |->
    $past(host_status_o[HPM_B_MBOUT] ||
    (host_status_o[HPM_B_MSGA] && msg_irq_en_i[0]) ||
    (host_status_o[HPM_B_MSGB] && msg_irq_en_i[1]) ||
    (|(host_status_o & irq_route_i & HPM_ROUTED_MASK))))
    else $error("host irq without cause");
endmodule

// ==== rtl/hpm_pkg.sv ====
/*
  constants, types and register layout for the host port mailbox and status block.
  assumes one system clock and an active-low asynchronous reset.
*/
package hpm_pkg;
  // ---------------------------------------------------------------
  // addresses and mailbox reset value
  // ---------------------------------------------------------------
  localparam logic [15:0] HPM_MBOX_ADDR = 16'hc0c6;
  localparam logic [15:0] HPM_MSG_A_ADDR = 16'h0144;
  localparam logic [15:0] HPM_MSG_B_ADDR = 16'h0148;
  localparam logic [15:0] HPM_MBOX_RST = 16'h0000;
  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int HPM_B_VBUS = 15;
  localparam int HPM_B_ID = 14;
  localparam int HPM_B_SOF2 = 12;
  localparam int HPM_B_SOF1 = 10;
  localparam int HPM_B_RST2 = 9;
  localparam int HPM_B_MBIN = 8;
  localparam int HPM_B_RES2 = 7;
  localparam int HPM_B_RES1 = 6;
  localparam int HPM_B_MSGB = 5;
  localparam int HPM_B_MSGA = 4;
  localparam int HPM_B_DONE2 = 3;
  localparam int HPM_B_DONE1 = 2;
  localparam int HPM_B_RST1 = 1;
  localparam int HPM_B_MBOUT = 0;
  // routed engine events, one bit per status position
  localparam logic [15:0] HPM_ROUTED_MASK = 16'h16ce;
  // bus-voltage settle time after power-up, and its cycle count at 250 MHz
  localparam int HPM_VBUS_SETTLE_NS = 10000;
  localparam int HPM_CLK_NS = 4;
  localparam int HPM_VBUS_SETTLE_CYC = HPM_VBUS_SETTLE_NS / HPM_CLK_NS;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hpm_acc_t;
  typedef struct packed {
    logic [15:0] mbox;
    logic rx_full;
    logic tx_empty;
    logic mb_in;
    logic mb_out;
    logic msg_a;
    logic msg_b;
    logic [15:0] events;
    logic irq;
    logic [15:0] cpu_rdata;
    logic [15:0] host_rdata;
    logic [1:0] vbus_sync;
    logic [1:0] id_sync;
  } hpm_state_t;
endpackage

// ==== bench/hpm_host_model.sv ====
/*
  external host processor model on the parallel host port.
  assumes callers enter its tasks 1 ns after a rising clock edge.
*/
`timescale 1ns/1ps
module hpm_host_model (
  input wire logic clock_i, // system clock
  output hpm_pkg::hpm_acc_t host_o, // host access
  output logic stat_rd_o // status port read
);
  import hpm_pkg::*;
  // ------------------------------------------------
  // accesses held over one edge, released lines scrambled
  // ------------------------------------------------
  initial begin
    host_o = '0;
    stat_rd_o = 1'b0;
  end
  task automatic acc(input logic r, input logic w, input logic [15:0] a, input logic [15:0] d);
    host_o = '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clock_i);
    #1 host_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // status read has no address, so no memory cycle inside
  task automatic stat();
    stat_rd_o = 1'b1;
    @(posedge clock_i);
    #1 stat_rd_o = 1'b0;
  endtask
  // bus voltage flag is untrusted until settled
  task automatic vbus_wait();
    repeat (HPM_VBUS_SETTLE_CYC) @(posedge clock_i);
    #1;
  endtask
endmodule

// ==== bench/tb_top.sv ====
/*
  self-checking bench for the host port mailbox block.
  assumes hpm_mailbox and the host model; 250 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import hpm_pkg::*;
  logic clock_i = 1'b0, rst_b_i = 1'b0, vbus = 1'b0, id = 1'b0, rxe = 1'b1, txe_en = 1'b1;
  logic stat_rd, rxf, txe, irq;
  logic [1:0] msg_en = 2'b00;
  logic [15:0] route = '0, ev = '0, evclr = '0, cpu_rd, host_rd, status, cpu_ev, e;
  logic [31:0] lfsr = 32'he322f96b;
  logic [15:0] exp_q[$];
  hpm_acc_t cpu_acc = '0, host_acc;
  int err_count = 0, compares = 0;
  always #2 clock_i = ~clock_i;
  hpm_mailbox dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .cpu_i(cpu_acc),
    .cpu_rdata_o(cpu_rd), .host_i(host_acc), .host_rdata_o(host_rd),
    .host_stat_rd_i(stat_rd), .host_status_o(status), .irq_route_i(route),
    .msg_irq_en_i(msg_en), .rx_full_en_i(rxe), .tx_empty_en_i(txe_en),
    .usb_event_i(ev), .usb_evclr_i(evclr), .vbus_valid_i(vbus), .otg_id_i(id),
    .mbox_receive_full_irq_o(rxf), .mbox_transmit_empty_irq_o(txe),
    .cpu_events_o(cpu_ev), .host_port_irq_out_o(irq));
  hpm_host_model host_u (.clock_i(clock_i), .host_o(host_acc), .stat_rd_o(stat_rd));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic cpu(input logic r, input logic w, input logic [15:0] a, input logic [15:0] d);
    cpu_acc = '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clock_i);
    #1 cpu_acc = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------
  // read monitor: oldest note against the registered read data
  // ------------------------------------------------
  always @(posedge clock_i) begin
    if (cpu_acc.rd === 1'b1 || host_acc.rd === 1'b1 || stat_rd === 1'b1) begin
      #2;
      if (exp_q.size() == 0) begin
        err_count++;
        $display("BAD rdata exp none got %h", cpu_rd | host_rd);
      end else begin
        chk("rdata", exp_q.pop_front(), cpu_rd | host_rd);
      end
    end
  end
  // watchdog: a hang ends in the same report
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    tick(1);
    exp_q.push_back(16'h0000);
    cpu(1'b1, 1'b0, HPM_MBOX_ADDR, 16'h0000);
    chk("status", 16'h0000, status);
    // mailbox both ways, random data and enables
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      {rxe, txe_en} = lfsr[17:16];
      cpu(1'b0, 1'b1, HPM_MBOX_ADDR, lfsr[15:0]);
      tick(1);
      chk("mb_out", 16'h0001, status & 16'h0001);
      chk("txe", 16'h0000, {15'h0, txe});
      chk("irq", 16'h0001, {15'h0, irq});
      exp_q.push_back(lfsr[15:0]);
      host_u.acc(1'b1, 1'b0, HPM_MBOX_ADDR, 16'h0000);
      tick(1);
      chk("mb_out", 16'h0000, status & 16'h0001);
      chk("txe", {15'h0, txe_en}, {15'h0, txe});
      chk("irq", 16'h0000, {15'h0, irq});
      host_u.acc(1'b0, 1'b1, HPM_MBOX_ADDR, ~lfsr[15:0]);
      tick(1);
      chk("mb_in", 16'h0100, status & 16'h0100);
      chk("rxf", {15'h0, rxe}, {15'h0, rxf});
      exp_q.push_back(~lfsr[15:0]);
      cpu(1'b1, 1'b0, HPM_MBOX_ADDR, 16'h0000);
      tick(1);
      chk("mb_in", 16'h0000, status & 16'h0100);
      chk("rxf", 16'h0000, {15'h0, rxf});
    end
    // message flags, enable then disable, cleared by host read
    for (int k = 0; k < 2; k++) begin
      e = 16'h0010 << k;
      msg_en = 2'b01 << k;
      cpu(1'b0, 1'b1, k ? HPM_MSG_B_ADDR : HPM_MSG_A_ADDR, lfsr[15:0]);
      tick(1);
      chk("msg", e, status & 16'h0030);
      chk("irq", 16'h0001, {15'h0, irq});
      msg_en = 2'b10 >> k;
      tick(2);
      chk("irq", 16'h0000, {15'h0, irq});
      exp_q.push_back(16'h0000);
      host_u.acc(1'b1, 1'b0, k ? HPM_MSG_B_ADDR : HPM_MSG_A_ADDR, 16'h0000);
      tick(1);
      chk("msg", 16'h0000, status & 16'h0030);
    end
    // engine events, routed to host or left with the cpu
    for (int b = 0; b < 16; b++) begin
      for (int r = 0; r < 2 && HPM_ROUTED_MASK[b]; r++) begin
        e = 16'h0001 << b;
        route = r ? e : 16'h0000;
        ev = e;
        tick(1);
        ev = '0;
        tick(1);
        chk("ev_host", route, status & HPM_ROUTED_MASK);
        chk("ev_cpu", r ? 16'h0000 : e, cpu_ev & e);
        chk("irq", 16'(r), {15'h0, irq});
        evclr = e;
        tick(1);
        evclr = '0;
        tick(2);
      end
    end
    // pins, reserved bits, status port, unmapped places
    vbus = 1'b1;
    id = 1'b1;
    host_u.vbus_wait();
    chk("pins", 16'hc000, status & 16'hc000);
    chk("resv", 16'h0000, status & 16'h2800);
    exp_q.push_back(16'hc000);
    host_u.stat();
    exp_q.push_back(16'h0000);
    cpu(1'b1, 1'b0, 16'h0142, 16'h0000);
    exp_q.push_back(16'h0000);
    host_u.acc(1'b1, 1'b0, 16'h0002, 16'h0000);
    id = 1'b0;
    tick(3);
    chk("pins", 16'h8000, status & 16'hc000);
    final_report();
  end
endmodule
